// *** verilog/irq_pkg.sv ***
// How it works
// - Software trap is taken whatever the mask, except that it waits while the mask set by serving an earlier request stays on; vector pair 1FFC/1FFD.
// - Unmasked requests pending at trap fetch go first; later ones wait until after the trap.
// - Mask set holds off every maskable request; clearing it lets them through.
// - Falling edge on request pin is synchronised, latched, vectored via 1FFA/1FFB.
// - Port-B pins with pull-up enabled merge into the request-pin logic.
// - Build option picks edge-only or level-and-edge triggering.
// - Request latch clears when servicing starts, so a new pulse is kept.
// - Any timer flag with its enable gives one timer request, vector 1FF8/1FF9.
// - Any of five async-serial flags with enable gives one request, vector 1FF6/1FF7.
// - Either sync-serial flag with enable gives one request, vector 1FF4/1FF5.
// - Power-up holds reset 4064 cycles, longer while reset pin stays low.
// - 18-bit watchdog, 64 ms at 2 MHz, timeout resets like power-on.
// - Writing zero to bit 0 at 1FF0 restarts watchdog; reads give program byte.
// - Watchdog keeps counting in wait mode.
// - Watchdog clears on stop entry; interrupt exit keeps the 4064 recovery counts.
// - Self-check mode forces the watchdog off.
// - Stop switches the oscillator off and halts internal activity.
// - Stop entry cancels timer requests, clears timer prescaler, clears mask.
// - Only an external request or a reset ends stop mode.
// - Wait halts the core, keeps clocks, clears mask, resumes on any request.
// - Any reset sets the mask and vectors through 1FFE/1FFF.
// - External request beats a timer request pending at the same boundary.
package irq_pkg;
   // Service address pairs, first byte of each pair
   localparam int VEC_W = 13;
   localparam logic [12:0] VEC_RESET = 13'h1ffe;
   localparam logic [12:0] VEC_TRAP = 13'h1ffc;
   localparam logic [12:0] VEC_EXT = 13'h1ffa;
   localparam logic [12:0] VEC_TIMER = 13'h1ff8;
   localparam logic [12:0] VEC_ASYNC = 13'h1ff6;
   localparam logic [12:0] VEC_SYNC = 13'h1ff4;

   // Request vector order: bit 0 external, 1 timer, 2 async serial, 3 sync serial
   localparam int REQ_W = 4;

   // Register byte addresses; each register is one aligned word
   localparam int IDX_W = 14;
   localparam logic [13:0] IDX_WDT_SERVICE = 14'h1ff0;
   localparam logic [13:0] IDX_CTRL = 14'h1fe0;
   localparam logic [13:0] IDX_STATUS = 14'h1fe4;
   localparam int WDT_CLR_BIT = 0;

   // Control register: port-B pull-up enables and watchdog option
   localparam int CTRL_W = 9;
   localparam int CTRL_PULLUP_LSB = 0;
   localparam int CTRL_WDT_EN_BIT = 8;
   localparam logic [8:0] CTRL_RESET = 9'h100;

   // Status register fields
   localparam int STATUS_W = 10;
   localparam int STATUS_REQ_LSB = 0;
   localparam int STATUS_MASK_BIT = 4;
   localparam int STATUS_TRAP_BIT = 5;
   localparam int STATUS_MODE_LSB = 6;

   // Timing
   localparam int OSC_CNT_W = 12;
   localparam int OSC_DELAY_CYCLES = 4064;
   localparam logic [11:0] OSC_DELAY_LAST = 12'(OSC_DELAY_CYCLES - 1);
   localparam int RESET_PIN_MIN_CYCLES = 2;
   localparam int HCLK_KHZ = 40000;
   localparam int BUS_RATE_KHZ = 2000;
   localparam int WDT_TIMEOUT_MS = 64;
   localparam int WDT_TIMEOUT_TICKS_DEF = WDT_TIMEOUT_MS * BUS_RATE_KHZ;
   localparam int BUS_TICK_DIV_DEF = HCLK_KHZ / BUS_RATE_KHZ;

   // Power modes
   typedef enum logic [3:0] {
      MODE_RUN = 4'b0001,
      MODE_WAIT = 4'b0010,
      MODE_STOP = 4'b0100,
      MODE_RECOVER = 4'b1000
   } power_mode_t;
endpackage

// *** verilog/ext_request_detect.sv ***
module ext_request_detect #(
   parameter bit LEVEL_AND_EDGE = 1'b0,
   parameter int PORTB_WIDTH = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ext_request_n,
   input wire logic [PORTB_WIDTH-1:0] portb_pins,
   input wire logic [PORTB_WIDTH-1:0] portb_pullup_en,
   input wire logic clear,
   output logic request
);
   logic line_n;
   logic sync_a, sync_b, line_prev, latch;
   logic next_sync_a, next_sync_b, next_line_prev, next_latch;

   generate
      if (PORTB_WIDTH < 1) begin : g_bad_width
         $error("Port-B width must be at least one");
      end
   endgenerate

   // Enabled port-B pins pull the shared request line low like the pin does
   assign line_n = ext_request_n & (&(portb_pins | ~portb_pullup_en));

   // Two-stage synchroniser, then edge latch; a new edge wins over the clear
   always_comb begin
      next_sync_a = line_n;
      next_sync_b = sync_a;
      next_line_prev = sync_b;
      next_latch = latch;
      if (clear) begin
         next_latch = 1'b0;
      end
      if (line_prev && !sync_b) begin
         next_latch = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
         line_prev <= 1'b1;
         latch <= 1'b0;
      end else begin
         sync_a <= next_sync_a;
         sync_b <= next_sync_b;
         line_prev <= next_line_prev;
         latch <= next_latch;
      end
   end

   // Level option keeps asking while the line stays low
   assign request = latch || (LEVEL_AND_EDGE && !sync_b);

   a_edge_latch: assert property (@(posedge hclk) disable iff (!hresetn)
      (line_prev && !sync_b) |=> request)
      else $error("Falling edge was not latched");
endmodule

// *** verilog/reset_sequencer.sv ***
module reset_sequencer (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic reset_pin_n,
   input wire logic wdt_timeout,
   input wire logic stopped,
   output logic core_reset
);
   import irq_pkg::*;

   logic [RESET_PIN_MIN_CYCLES-1:0] pin_hist, next_pin_hist;
   logic [OSC_CNT_W-1:0] cnt, next_cnt;
   logic pin_low;

   generate
      if (RESET_PIN_MIN_CYCLES < 2) begin : g_bad_filter
         $error("Reset pin filter needs at least two samples");
      end
   endgenerate

   // Shorter pulses than the minimum are ignored as glitches
   assign pin_low = (pin_hist == '0);

   // Delay restarts after watchdog timeout, or a pin reset out of stop
   always_comb begin
      next_pin_hist = {pin_hist[RESET_PIN_MIN_CYCLES-2:0], reset_pin_n};
      next_cnt = cnt;
      if (wdt_timeout || (stopped && pin_low)) begin
         next_cnt = '0;
      end else if (cnt != OSC_DELAY_LAST) begin
         next_cnt = OSC_CNT_W'(cnt + 1'b1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_hist <= '1;
         cnt <= '0;
      end else begin
         pin_hist <= next_pin_hist;
         cnt <= next_cnt;
      end
   end

   assign core_reset = (cnt != OSC_DELAY_LAST) || pin_low;

   a_release_late: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(core_reset) |-> (cnt == OSC_DELAY_LAST) && !pin_low && $past(cnt) != '0)
      else $error("Reset released before the start-up delay");
endmodule

// *** verilog/irq_reset_lowpower_ctrl.sv ***
module irq_reset_lowpower_ctrl #(
   parameter int WDT_BITS = 18,
   parameter int WDT_TIMEOUT_TICKS = irq_pkg::WDT_TIMEOUT_TICKS_DEF,
   parameter int BUS_TICK_DIV = irq_pkg::BUS_TICK_DIV_DEF,
   parameter bit LEVEL_AND_EDGE = 1'b0,
   parameter int PORTB_WIDTH = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic ext_request_n,
   input wire logic [PORTB_WIDTH-1:0] portb_pins,
   input wire logic reset_pin_n,
   input wire logic self_check_mode,
   input wire logic [7:0] rom_service_byte,
   input wire logic [2:0] timer_status,
   input wire logic [2:0] timer_control,
   input wire logic [4:0] async_serial_status,
   input wire logic [4:0] async_serial_control_two,
   input wire logic [1:0] sync_serial_status,
   input wire logic [1:0] sync_serial_control,
   input wire logic instr_boundary,
   input wire logic trap_fetch,
   input wire logic stop_exec,
   input wire logic wait_exec,
   input wire logic mask_set,
   input wire logic mask_clear,
   output logic core_reset,
   output logic service_take,
   output logic [irq_pkg::VEC_W-1:0] service_vector,
   output logic irq_mask,
   output logic osc_enable,
   output logic cpu_halt,
   output logic timer_stop_clear
);
   import irq_pkg::*;

   localparam int TICK_W = $clog2(BUS_TICK_DIV + 1);

   generate
      if (WDT_TIMEOUT_TICKS < 2 || WDT_TIMEOUT_TICKS > (2 ** WDT_BITS)) begin : g_bad_wdt
         $error("Watchdog timeout does not fit the counter");
      end
      if (BUS_TICK_DIV < 1 || PORTB_WIDTH > 8) begin : g_bad_div
         $error("Bus tick divider or port-B width out of range");
      end
   endgenerate

   // Exact byte address match; used for both bus phases
   function automatic logic is_reg(input logic [31:0] addr, input logic [IDX_W-1:0] idx);
      return addr == {18'h00000, idx};
   endfunction

   // Lowest set bit wins, which is the highest vector address
   function automatic logic [REQ_W-1:0] pick_first(input logic [REQ_W-1:0] r);
      return r & REQ_W'(~r + 1'b1);
   endfunction

   function automatic logic [VEC_W-1:0] vec_of(input logic [REQ_W-1:0] one);
      logic [VEC_W-1:0] v;
      v = VEC_SYNC;
      if (one[0]) begin
         v = VEC_EXT;
      end else if (one[1]) begin
         v = VEC_TIMER;
      end else if (one[2]) begin
         v = VEC_ASYNC;
      end
      return v;
   endfunction

   logic ext_req, ext_clear, wdt_timeout, wdt_clear_wr, stop_entry, bus_tick, wdt_run;
   logic [REQ_W-1:0] hw_req, live;
   logic [CTRL_W-1:0] ctrl, next_ctrl;
   logic [STATUS_W-1:0] status;
   logic dp_write, next_dp_write;
   logic [31:0] dp_addr, next_dp_addr, next_hrdata;
   logic [TICK_W-1:0] tick_cnt, next_tick_cnt;
   logic [WDT_BITS-1:0] wdt_cnt, next_wdt_cnt;
   power_mode_t mode, next_mode;
   logic next_mask, trap_pending, next_trap, hold_trap, next_hold;
   logic [REQ_W-1:0] snap, next_snap;
   logic next_take, next_stop_clr;
   logic [VEC_W-1:0] next_vec;
   logic [OSC_CNT_W-1:0] rec_cnt, next_rec;

   // Flag and enable pairs fold into one request per source group
   assign hw_req = {|(sync_serial_status & sync_serial_control),
                    |(async_serial_status & async_serial_control_two),
                    |(timer_status & timer_control),
                    ext_req};

   ext_request_detect #(
      .LEVEL_AND_EDGE(LEVEL_AND_EDGE),
      .PORTB_WIDTH(PORTB_WIDTH)
   ) u_ext (
      .hclk(hclk),
      .hresetn(hresetn),
      .ext_request_n(ext_request_n),
      .portb_pins(portb_pins),
      .portb_pullup_en(ctrl[CTRL_PULLUP_LSB +: PORTB_WIDTH]),
      .clear(ext_clear),
      .request(ext_req)
   );

   reset_sequencer u_rst (
      .hclk(hclk),
      .hresetn(hresetn),
      .reset_pin_n(reset_pin_n),
      .wdt_timeout(wdt_timeout),
      .stopped(mode == MODE_STOP),
      .core_reset(core_reset)
   );

   // Zero-wait slave: read data is prepared in the address phase
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   assign status[STATUS_REQ_LSB +: REQ_W] = hw_req;
   assign status[STATUS_MASK_BIT] = irq_mask;
   assign status[STATUS_TRAP_BIT] = trap_pending;
   assign status[STATUS_MODE_LSB +: 4] = mode;

   // Bus phases; only whole-word transfers are expected, so hsize is not decoded
   always_comb begin
      next_dp_write = hsel && hready && htrans[1] && hwrite;
      next_dp_addr = haddr;
      next_hrdata = hrdata;
      next_ctrl = ctrl;
      if (hsel && hready && htrans[1] && !hwrite) begin
         if (is_reg(haddr, IDX_WDT_SERVICE)) begin
            next_hrdata = {24'h000000, rom_service_byte};
         end else if (is_reg(haddr, IDX_CTRL)) begin
            next_hrdata = {{(32-CTRL_W){1'b0}}, ctrl};
         end else if (is_reg(haddr, IDX_STATUS)) begin
            next_hrdata = {{(32-STATUS_W){1'b0}}, status};
         end else begin
            next_hrdata = '0;
         end
      end
      if (dp_write && is_reg(dp_addr, IDX_CTRL)) begin
         next_ctrl = hwdata[CTRL_W-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         dp_addr <= '0;
         hrdata <= '0;
         ctrl <= CTRL_RESET;
      end else begin
         dp_write <= next_dp_write;
         dp_addr <= next_dp_addr;
         hrdata <= next_hrdata;
         ctrl <= next_ctrl;
      end
   end

   // Only a zero in the clear bit services the watchdog; a one is ignored
   assign wdt_clear_wr = dp_write && is_reg(dp_addr, IDX_WDT_SERVICE) &&
                         !hwdata[WDT_CLR_BIT];
   assign stop_entry = (mode == MODE_RUN) && stop_exec && !core_reset;
   assign bus_tick = (tick_cnt == TICK_W'(BUS_TICK_DIV - 1));
   // Oscillator off in stop freezes it; wait mode still counts
   assign wdt_run = ctrl[CTRL_WDT_EN_BIT] && !self_check_mode &&
                    (mode != MODE_STOP) && !core_reset;
   assign wdt_timeout = wdt_run && bus_tick &&
                        (wdt_cnt == WDT_BITS'(WDT_TIMEOUT_TICKS - 1));

   // Watchdog counts bus ticks; recovery from stop counts too
   always_comb begin
      next_tick_cnt = bus_tick ? '0 : TICK_W'(tick_cnt + 1'b1);
      next_wdt_cnt = wdt_cnt;
      if (mode == MODE_STOP) begin
         next_tick_cnt = '0;
      end
      if (core_reset || wdt_clear_wr || stop_entry) begin
         next_wdt_cnt = '0;
      end else if (wdt_run && bus_tick) begin
         next_wdt_cnt = WDT_BITS'(wdt_cnt + 1'b1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt <= '0;
         wdt_cnt <= '0;
      end else begin
         tick_cnt <= next_tick_cnt;
         wdt_cnt <= next_wdt_cnt;
      end
   end

   // Requests seen at trap fetch that are still pending
   assign live = snap & hw_req;

   // Arbitration and power modes; reset overrides everything at the end
   always_comb begin
      next_mode = mode;
      next_mask = irq_mask;
      next_trap = trap_pending;
      next_hold = hold_trap;
      next_snap = snap;
      next_take = 1'b0;
      next_vec = service_vector;
      next_stop_clr = 1'b0;
      next_rec = rec_cnt;
      if (mask_set) begin
         next_mask = 1'b1;
      end else if (mask_clear) begin
         next_mask = 1'b0;
      end
      if (!irq_mask) begin
         next_hold = 1'b0;
      end
      case (mode)
         MODE_RUN: begin
            if (stop_exec) begin
               next_mode = MODE_STOP;
               next_mask = 1'b0;
               next_stop_clr = 1'b1;
            end else if (wait_exec) begin
               next_mode = MODE_WAIT;
               next_mask = 1'b0;
            end else if (instr_boundary) begin
               if (trap_pending && !irq_mask && live != '0) begin
                  next_take = 1'b1;
                  next_vec = vec_of(pick_first(live));
                  next_snap = snap & ~pick_first(live);
                  next_hold = 1'b1;
                  next_mask = 1'b1;
               end else if (trap_pending && !(irq_mask && hold_trap)) begin
                  next_take = 1'b1;
                  next_vec = VEC_TRAP;
                  next_trap = 1'b0;
                  next_snap = '0;
                  next_hold = 1'b0;
                  next_mask = 1'b1;
               end else if (!trap_pending && !irq_mask && hw_req != '0) begin
                  next_take = 1'b1;
                  next_vec = vec_of(pick_first(hw_req));
                  next_mask = 1'b1;
               end
            end
         end
         MODE_WAIT: begin
            if (hw_req != '0) begin
               next_mode = MODE_RUN;
            end
         end
         MODE_STOP: begin
            if (ext_req) begin
               next_mode = MODE_RECOVER;
               next_rec = '0;
            end
         end
         MODE_RECOVER: begin
            if (rec_cnt == OSC_DELAY_LAST) begin
               next_mode = MODE_RUN;
            end else begin
               next_rec = OSC_CNT_W'(rec_cnt + 1'b1);
            end
         end
         default: begin
            next_mode = MODE_RUN;
         end
      endcase
      // A new fetch beats a trap service in the same cycle, so no trap is lost
      if (trap_fetch) begin
         next_trap = 1'b1;
         next_snap = irq_mask ? '0 : hw_req;
      end
      if (core_reset) begin
         next_mode = MODE_RUN;
         next_mask = 1'b1;
         next_trap = 1'b0;
         next_hold = 1'b0;
         next_snap = '0;
         next_take = 1'b0;
         next_vec = VEC_RESET;
         next_stop_clr = 1'b0;
         next_rec = '0;
      end
   end

   // Latch clears on the same edge that announces the service
   assign ext_clear = next_take && (next_vec == VEC_EXT);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode <= MODE_RUN;
         irq_mask <= 1'b1;
         trap_pending <= 1'b0;
         hold_trap <= 1'b0;
         snap <= '0;
         service_take <= 1'b0;
         service_vector <= VEC_RESET;
         timer_stop_clear <= 1'b0;
         rec_cnt <= '0;
      end else begin
         mode <= next_mode;
         irq_mask <= next_mask;
         trap_pending <= next_trap;
         hold_trap <= next_hold;
         snap <= next_snap;
         service_take <= next_take;
         service_vector <= next_vec;
         timer_stop_clear <= next_stop_clr;
         rec_cnt <= next_rec;
      end
   end

   // Core halts outside run; oscillator stays on except in stop
   assign cpu_halt = (mode != MODE_RUN);
   assign osc_enable = (mode != MODE_STOP);

   // Checks
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   logic at_bnd;
   assign at_bnd = instr_boundary && (mode == MODE_RUN) && !stop_exec && !wait_exec &&
                   !core_reset;

   a_trap_unmasked: assert property (
      at_bnd && trap_pending && irq_mask && !hold_trap |=>
      service_take && service_vector == VEC_TRAP)
      else $error("Trap not taken while masked");
   a_trap_after_pending: assert property (
      at_bnd && trap_pending && !irq_mask && live != '0 |=>
      service_take && service_vector != VEC_TRAP)
      else $error("Trap overtook an earlier request");
   a_mask_holds: assert property (
      at_bnd && irq_mask && !trap_pending |=> !service_take)
      else $error("Request taken while masked");
   a_ext_first: assert property (
      at_bnd && !irq_mask && !trap_pending && ext_req |=>
      service_take && service_vector == VEC_EXT && irq_mask)
      else $error("External request not served first");
   a_timer_vector: assert property (
      at_bnd && !irq_mask && !trap_pending && hw_req[1:0] == 2'b10 |=>
      service_vector == VEC_TIMER)
      else $error("Wrong timer vector");
   a_async_vector: assert property (
      at_bnd && !irq_mask && !trap_pending && hw_req[2:0] == 3'b100 |=>
      service_vector == VEC_ASYNC)
      else $error("Wrong async serial vector");
   a_sync_vector: assert property (
      at_bnd && !irq_mask && !trap_pending && hw_req == 4'h8 |=>
      service_vector == VEC_SYNC)
      else $error("Wrong sync serial vector");
   a_reset_vector: assert property (
      $fell(core_reset) |-> irq_mask && service_vector == VEC_RESET && !service_take)
      else $error("Reset did not set mask and vector");
   a_stop_entry: assert property (
      stop_entry |=> mode == MODE_STOP && !irq_mask && timer_stop_clear && !osc_enable
      ##1 !timer_stop_clear)
      else $error("Stop entry effects missing");
   a_stop_exit: assert property (
      mode == MODE_STOP && !ext_req && !core_reset |=> mode == MODE_STOP || core_reset)
      else $error("Stop left without cause");
   a_wdt_stop: assert property (
      mode == MODE_STOP |-> wdt_cnt == '0)
      else $error("Watchdog not clear in stop");
   a_wdt_service: assert property (
      wdt_clear_wr |=> wdt_cnt == '0)
      else $error("Watchdog service write ignored");
   a_wdt_wait: assert property (
      mode == MODE_WAIT && wdt_run && bus_tick && !wdt_clear_wr |=>
      wdt_cnt == WDT_BITS'($past(wdt_cnt) + 1'b1))
      else $error("Watchdog stalled in wait");
   a_self_check: assert property (
      self_check_mode && !core_reset && !wdt_clear_wr && !stop_entry |=>
      wdt_cnt == $past(wdt_cnt))
      else $error("Watchdog ran in self-check");
   a_wdt_reset: assert property (
      wdt_timeout |=> core_reset [*2])
      else $error("Watchdog timeout did not reset");
   a_wait_exit: assert property (
      mode == MODE_WAIT && hw_req != '0 && !core_reset |=> mode == MODE_RUN)
      else $error("Wait not left on request");

   c_trap_taken: cover property (service_take && service_vector == VEC_TRAP);
   c_stop_recover: cover property (mode == MODE_RECOVER ##1 mode == MODE_RUN);
   c_wdt_timeout: cover property (wdt_timeout);
   c_wait_exit: cover property (mode == MODE_WAIT ##1 mode == MODE_RUN);
endmodule

// *** verification/core_model.sv ***
module core_model #(parameter int GAP = 4) (
   input wire logic hclk,
   input wire logic core_reset,
   input wire logic cpu_halt,
   output logic instr_boundary = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   // Boundary every GAP cycles; a halted or reset core completes nothing
   always @(posedge hclk) begin
      cnt <= (core_reset || cpu_halt || cnt == GAP - 1) ? 0 : cnt + 1;
      instr_boundary <= !core_reset && !cpu_halt && cnt == GAP - 1;
   end
endmodule

// *** verification/irq_reset_lowpower_ctrl_tb_top.sv ***
module irq_reset_lowpower_ctrl_tb_top;
   import irq_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ext_n = 1, sck = 1, rpin = 1;
   logic [31:0] haddr = 0, hwdata = 0, rd, rdata, lfsr = 32'h6c2f;
   logic [1:0] htrans = 0, sy = 0;
   logic [2:0] tm = 0, tctl = 3'h7;
   logic [4:0] as = 0, ctl = 0;
   logic [7:0] pb = 8'hff, rom = 0;
   logic hreadyout, hresp, core_reset, service_take, irq_mask, osc_enable, cpu_halt, bnd, tsc;
   logic [12:0] service_vector;
   int n_fail = 0, checks = 0, cyc = 0, w;
   irq_reset_lowpower_ctrl #(.WDT_TIMEOUT_TICKS(50), .BUS_TICK_DIV(2)) dut_u (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata(rdata), .hresp, .ext_request_n(ext_n),
      .portb_pins(pb), .reset_pin_n(rpin), .self_check_mode(sck), .rom_service_byte(rom),
      .timer_status(tm), .timer_control(tctl), .async_serial_status(as),
      .async_serial_control_two(5'h1f), .sync_serial_status(sy), .sync_serial_control(2'h3),
      .instr_boundary(bnd), .mask_clear(ctl[0]), .mask_set(ctl[1]), .trap_fetch(ctl[2]),
      .stop_exec(ctl[3]), .wait_exec(ctl[4]), .core_reset, .service_take, .service_vector,
      .irq_mask, .osc_enable, .cpu_halt, .timer_stop_clear(tsc));
   core_model #(.GAP(4)) core_u (.hclk, .core_reset, .cpu_halt, .instr_boundary(bnd));
   initial forever #12.5 hclk = ~hclk;
   // Model: lowest request index wins, vectors step down by two
   function automatic logic [12:0] pick(logic [3:0] p);
      pick = VEC_RESET;
      for (int i = 3; i >= 0; i--) if (p[i]) pick = VEC_EXT - 13'(2 * i);
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checks++;
      if (e !== g) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Single AHB word; waits on hready in both phases, data taken at the second edge
   task automatic bus(logic wr, logic [31:0] a, logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = rdata;
      chk("hresp", 0, hresp);
   endtask
   task automatic pulse(int b);
      @(posedge hclk);
      ctl <= 5'(1 << b);
      @(posedge hclk);
      ctl <= 5'h0;
   endtask
   task automatic svc(logic [12:0] v);
      w = 0;
      do @(negedge hclk); while (service_take !== 1'b1 && ++w < 80);
      chk("vector", {19'h1, v}, {service_take, service_vector});
      @(posedge hclk);
   endtask
   task automatic give_verdict();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Hang guard: whole run is near 8700 cycles
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         give_verdict();
      end
   end
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      w = 0;
      do @(negedge hclk); while (core_reset !== 1'b0 && ++w < 5000);
      chk("por", 1, w > 4061 && w < 4067);
      chk("rstv", {19'h1, VEC_RESET}, {irq_mask, service_vector});
      // Pin held low three cycles, one more than the filter length
      @(posedge hclk);
      rpin <= 1'b0;
      repeat (3) @(negedge hclk);
      chk("pinrst", 1, core_reset);
      @(posedge hclk);
      rpin <= 1'b1;
      repeat (3) @(negedge hclk);
      chk("pinrel", 0, core_reset);
      bus(0, 32'(IDX_CTRL), 0);
      chk("ctrl0", 32'(CTRL_RESET), rd);
      bus(1, 32'(IDX_CTRL), 32'h104);
      bus(0, 32'(IDX_CTRL), 0);
      chk("ctrl", 32'h104, rd);
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      rom <= lfsr[7:0];
      bus(0, 32'(IDX_WDT_SERVICE), 0);
      chk("rom", {24'h0, lfsr[7:0]}, rd);
      bus(0, 32'h100, 0);
      chk("unmap", 0, rd);
      pulse(0);
      ext_n <= 1'b0;
      svc(VEC_EXT);
      // Masked: pin B2 and timer wait; the line idles high first so B2 gives a fresh edge
      ext_n <= 1'b1;
      tm <= 3'h1;
      repeat (4) @(posedge hclk);
      pb[2] <= 1'b0;
      repeat (10) begin
         @(negedge hclk);
         chk("held", 0, service_take);
      end
      pulse(0);
      svc(pick(4'b0011));
      pb[2] <= 1'b1;
      pulse(0);
      svc(pick(4'b0010));
      // A flag without its enable asks for nothing
      tctl <= 3'h6;
      pulse(0);
      repeat (8) begin
         @(negedge hclk);
         chk("tmoff", 0, service_take);
      end
      pulse(1);
      tm <= 3'h0;
      for (int i = 2; i < 4; i++) begin
         as <= i == 2 ? 5'(1 << (lfsr % 5)) : 5'h0;
         sy <= i == 3 ? 2'h2 : 2'h0;
         pulse(0);
         svc(pick(4'(1 << i)));
      end
      sy <= 2'h0;
      pulse(2);
      svc(VEC_TRAP);
      pulse(4);
      repeat (2) @(negedge hclk);
      chk("wait", 2'b10, {cpu_halt, irq_mask});
      // Trap fetched as the waking request arrives: the request goes first
      @(posedge hclk);
      as <= 5'h1;
      ctl <= 5'h4;
      @(posedge hclk);
      ctl <= 5'h0;
      svc(VEC_ASYNC);
      as <= 5'h0;
      pulse(0);
      svc(VEC_TRAP);
      as <= 5'h1;
      pulse(3);
      @(negedge hclk);
      chk("tclr", 1, tsc);
      @(negedge hclk);
      chk("stop", 0, {osc_enable, irq_mask});
      repeat (10) @(negedge hclk);
      chk("stay", 1, cpu_halt & !osc_enable);
      @(posedge hclk);
      as <= 5'h0;
      ext_n <= 1'b0;
      w = 0;
      do @(negedge hclk); while (cpu_halt !== 1'b0 && ++w < 5000);
      chk("recov", 1, w > 4000);
      svc(VEC_EXT);
      // Watchdog live: fed three times, then left to expire
      sck <= 1'b0;
      repeat (3) begin
         repeat (60) @(posedge hclk);
         bus(1, 32'(IDX_WDT_SERVICE), 0);
      end
      chk("fed", 0, core_reset);
      w = 0;
      do @(negedge hclk); while (core_reset !== 1'b1 && ++w < 300);
      chk("bite", 1, w < 150);
      give_verdict();
   end
endmodule
